// >>> src/adc_filter_calibration.sv
/*
 Digital back end of a sigma-delta ADC channel: decimation, chop and averaging,
 running average, offset and gain correction, output formatting and the
 calibration sequencer, with registers on an AHB-Lite slave port.
 Assumes a single 20 MHz clock and a modulator that presents one bit per MOD_TICK_O.
*/

// Contract
// - Running-average bit adds an average of two consecutive output samples.
// - Running average adds one conversion period to settling.
// - Filter bit 15 enables chopping to cancel offset and its drift.
// - Decimation factor in bits 6:0, averaging factor in bits 13:8.
// - Decimation 0x1D, averaging 0x3F with chop gives 4 Hz in normal mode.
// - Low power modes clock the modulator and filter at 131 kHz, not 512 kHz.
// - Decimation 0x1F, averaging 0x3D, chop in low power gives 1 Hz.
// - Filter output is averaged when chopping, passed through otherwise; the code averages averaging factor plus one samples without chop.
// - Offset coefficient is subtracted, then the difference scaled by gain.
// - Result rounded to 16 bits, saturated, twos complement or offset binary.
// - Offset and gain coefficients load factory values at reset.
// - Coefficients writable only when idle; calibration overwrites them.
// - Self offset uses internal zero, self gain internal full scale.
// - System calibration uses an external signal held for the whole cycle.
// - Offset calibration lasts three periods, two with chop, then idle.
// - Gain calibration runs two stages, twice an offset calibration.
// - Calibration aborts conversion, runs at programmed rate, ends idle.
// - Filter bit 7 adds a second notch at 1.333 times the first.
// - Filter configuration resets to 0x0007.
// - Power mode is mode register bits 4:3.
`timescale 1ns/1ns
`default_nettype none
module adc_filter_calibration (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic MOD_BIT_I,
   output logic MOD_TICK_O,
   output logic CHOP_PHASE_O,
   output logic [1:0] INPUT_SEL_O,
   output logic [1:0] POWER_MODE_O
);
   typedef struct packed {
      logic [15:0] filt;
      logic [6:0] mode;

      logic [15:0] offs;
      logic [15:0] gain;

      logic [15:0] result;
      logic ready;

      adc_filter_pkg::ctl_state_t state;
      logic stage;
      logic [2:0] settle;
      logic [1:0] in_sel;

      logic [7:0] tick_cnt;
      logic tick;
      logic restart;
      logic chop_ph;

      logic signed [31:0] acc;
      logic [6:0] acc_n;
      logic signed [23:0] prev;

      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;

      logic [31:0] rdata;
      logic hready;
      logic hresp;
   } st_t;

   st_t s_r, n;

   adc_filter_pkg::sample_t dec;

   logic [7:0] div;

   logic mode_wr, chop, ravg, done;

   logic [2:0] code;

   logic [6:0] navg;

   logic signed [31:0] v, sum, quot;

   logic signed [24:0] pair;

   logic signed [23:0] avg, q24;

   logic signed [15:0] q;

   logic signed [16:0] d;

   logic signed [33:0] p, r;

   logic [15:0] fmt;

   logic [31:0] gq;

   // Last settle count: output periods up to and including the first valid result, minus one.
   function automatic logic [2:0] settle_last(input logic [15:0] f);
      logic [2:0] len;
      len = f[adc_filter_pkg::FLT_CHOP] ? adc_filter_pkg::SETTLE_CHOP
                                        : adc_filter_pkg::SETTLE_PLAIN;
      len = len + {2'h0, f[adc_filter_pkg::FLT_RAVG]};
      return len - 3'h1;
   endfunction

   // The decimator is held clear while the channel is idle.
   sinc3_decimator u_dec (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .restart_i(s_r.restart || s_r.state == adc_filter_pkg::ST_IDLE),
      .tick_i(s_r.tick),
      .bit_i(MOD_BIT_I),
      .sf_i(s_r.filt[adc_filter_pkg::FLT_SF_LSB +: 7]),
      .modify_i(s_r.filt[adc_filter_pkg::FLT_MODIFY]),
      .out_o(dec)
   );

   always_comb begin
      n = s_r;
      n.tick = 1'b0;
      n.restart = 1'b0;

      chop = s_r.filt[adc_filter_pkg::FLT_CHOP];
      ravg = s_r.filt[adc_filter_pkg::FLT_RAVG];
      code = HWDATA_I[2:0];
      mode_wr = s_r.ap_valid && s_r.ap_write && s_r.ap_addr == adc_filter_pkg::ADDR_MODE;

      // Modulator tick: 512 kHz in normal mode, 131 kHz in both low power modes.
      div = (s_r.mode[adc_filter_pkg::MODE_PWR_LSB +: 2] == adc_filter_pkg::PWR_NORMAL)
            ? adc_filter_pkg::TICK_DIV_NORMAL : adc_filter_pkg::TICK_DIV_LOW;
      if (s_r.tick_cnt >= div - 8'h01) begin
         n.tick_cnt = '0;
         n.tick = 1'b1;
      end else begin
         n.tick_cnt = s_r.tick_cnt + 8'h01;
      end

      // Write data phase.
      // Coefficient writes are dropped while a conversion or calibration runs.
      if (s_r.ap_valid && s_r.ap_write) begin
         case (s_r.ap_addr)
            adc_filter_pkg::ADDR_FILTER: n.filt = HWDATA_I[15:0];
            adc_filter_pkg::ADDR_MODE: n.mode = HWDATA_I[6:0];
            adc_filter_pkg::ADDR_OFFSET: begin
               if (s_r.state == adc_filter_pkg::ST_IDLE) n.offs = HWDATA_I[15:0];
            end
            adc_filter_pkg::ADDR_GAIN: begin
               if (s_r.state == adc_filter_pkg::ST_IDLE) n.gain = HWDATA_I[15:0];
            end
            default: ;
         endcase
      end

      // A mode write restarts the whole chain, halting any conversion in flight.
      if (mode_wr) begin
         n.restart = 1'b1;
         n.acc = '0;
         n.acc_n = '0;
         n.chop_ph = 1'b0;
         n.stage = 1'b0;
         n.settle = settle_last(n.filt);
         n.in_sel = adc_filter_pkg::SEL_EXTERNAL;
         n.state = adc_filter_pkg::ST_CAL;
         case (code)
            adc_filter_pkg::MODE_CONVERT: n.state = adc_filter_pkg::ST_CONV;
            adc_filter_pkg::MODE_SELF_OFFSET: n.in_sel = adc_filter_pkg::SEL_ZERO;
            adc_filter_pkg::MODE_SELF_GAIN: n.in_sel = adc_filter_pkg::SEL_FULL;
            adc_filter_pkg::MODE_SYS_OFFSET, adc_filter_pkg::MODE_SYS_GAIN: ;
            default: begin
               n.state = adc_filter_pkg::ST_IDLE;
               n.mode[2:0] = adc_filter_pkg::MODE_IDLE;
            end
         endcase
      end

      // Address phase; read data comes from the post-write image.
      n.ap_valid = HSEL_I && HTRANS_I[1] && HREADY_I;
      n.ap_write = HWRITE_I;
      n.ap_addr = HADDR_I[7:0];
      n.rdata = '0;
      if (n.ap_valid && !HWRITE_I) begin
         case (HADDR_I[7:0])
            adc_filter_pkg::ADDR_FILTER: n.rdata = {16'h0000, n.filt};
            adc_filter_pkg::ADDR_MODE: n.rdata = {25'h0000000, n.mode};
            adc_filter_pkg::ADDR_OFFSET: n.rdata = {16'h0000, n.offs};
            adc_filter_pkg::ADDR_GAIN: n.rdata = {16'h0000, n.gain};
            adc_filter_pkg::ADDR_RESULT: begin
               n.rdata = {16'h0000, n.result};
               n.ready = 1'b0;
            end
            adc_filter_pkg::ADDR_STATUS: begin
               n.rdata = {28'h0000000, n.stage, n.state != adc_filter_pkg::ST_IDLE,
                          n.state == adc_filter_pkg::ST_CAL, n.ready};
            end
            default: n.rdata = '0;
         endcase
      end

      // Chop demodulation and averaging of decimator outputs.
      v = {{8{dec.data[23]}}, dec.data};
      if (s_r.chop_ph) v = -v;
      // Samples per output: averaging factor plus three with chop, plus one without.
      navg = {1'b0, s_r.filt[adc_filter_pkg::FLT_AF_LSB +: 6]}
             + (chop ? adc_filter_pkg::AVG_EXTRA_CHOP : adc_filter_pkg::AVG_EXTRA_PLAIN);
      sum = s_r.acc + v;
      quot = sum / $signed({25'h0000000, navg});
      avg = quot[23:0];
      pair = {avg[23], avg} + {s_r.prev[23], s_r.prev};
      q24 = ravg ? pair[24:1] : avg;
      q = q24[23:8];
      done = 1'b0;
      if (dec.valid && s_r.state != adc_filter_pkg::ST_IDLE && !mode_wr) begin
         if (chop) n.chop_ph = ~s_r.chop_ph;
         if (s_r.acc_n + 7'h01 >= navg) begin
            n.acc = '0;
            n.acc_n = '0;
            n.prev = avg;
            done = 1'b1;
         end else begin
            n.acc = sum;
            n.acc_n = s_r.acc_n + 7'h01;
         end
      end

      // Offset and gain correction, rounding, saturation and format.
      d = {q[15], q} - {s_r.offs[15], s_r.offs};
      p = d * $signed({1'b0, s_r.gain});
      r = (p + adc_filter_pkg::ROUND_HALF) >>> adc_filter_pkg::GAIN_SHIFT;
      if (r > 34'sh0_0000_7FFF) fmt = 16'h7FFF;
      else if (r < -34'sh0_0000_8000) fmt = 16'h8000;
      else fmt = r[15:0];
      if (s_r.mode[adc_filter_pkg::MODE_FMT]) fmt = fmt ^ 16'h8000;
      // Gain target over the measured span; a span at or below zero clamps high.
      gq = (d > 17'sh0_0000) ? adc_filter_pkg::GAIN_TARGET / 32'(d) : 32'hFFFF_FFFF;

      // The settle count hides the first, incomplete outputs of the filter.

      if (done) begin
         if (s_r.settle != 3'h0) begin
            n.settle = s_r.settle - 3'h1;
         end else begin
            unique case (s_r.state)
               adc_filter_pkg::ST_IDLE: ;
               adc_filter_pkg::ST_CONV: begin
                  n.result = fmt;
                  n.ready = 1'b1;
               end
               adc_filter_pkg::ST_CAL: begin
                  // The first gain stage only primes the second.
                  if (s_r.mode[0] && !s_r.stage) begin
                     n.stage = 1'b1;
                     n.settle = settle_last(s_r.filt);
                  end else begin
                     if (s_r.mode[0]) n.gain = (gq > 32'h0000FFFF) ? 16'hFFFF : gq[15:0];
                     else n.offs = q;
                     n.mode[2:0] = adc_filter_pkg::MODE_IDLE;
                     n.state = adc_filter_pkg::ST_IDLE;
                     n.in_sel = adc_filter_pkg::SEL_EXTERNAL;
                  end
               end
            endcase
         end
      end
   end

   // Coefficients take their factory values at reset.
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         s_r <= '0;
         s_r.filt <= adc_filter_pkg::FILTER_RESET;
         s_r.offs <= adc_filter_pkg::OFFSET_FACTORY;
         s_r.gain <= adc_filter_pkg::GAIN_FACTORY;
         s_r.state <= adc_filter_pkg::ST_IDLE;
         s_r.hready <= 1'b1;
      end else begin
         s_r <= n;
      end
   end

   assign HRDATA_O = s_r.rdata;
   assign HREADYOUT_O = s_r.hready;
   assign HRESP_O = s_r.hresp;

   assign MOD_TICK_O = s_r.tick;
   assign CHOP_PHASE_O = s_r.chop_ph;
   assign INPUT_SEL_O = s_r.in_sel;
   assign POWER_MODE_O = s_r.mode[adc_filter_pkg::MODE_PWR_LSB +: 2];
endmodule // adc_filter_calibration
`default_nettype wire

// >>> src/adc_filter_pkg.sv
/*
 Shared constants and types for the sigma-delta ADC filter and calibration block:
 register map, field positions, reset values, mode codes and sample carriers.
 Assumes a 20 MHz system clock and a modulator bit stream sampled on an internal tick.
*/
`default_nettype none
package adc_filter_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned MOD_HZ_NORMAL = 512_000;
   localparam int unsigned MOD_HZ_LOW = 131_000;
   localparam logic [7:0] TICK_DIV_NORMAL = 8'(CLK_HZ / MOD_HZ_NORMAL);
   localparam logic [7:0] TICK_DIV_LOW = 8'(CLK_HZ / MOD_HZ_LOW);

   localparam logic [7:0] ADDR_FILTER = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_OFFSET = 8'h08;
   localparam logic [7:0] ADDR_GAIN = 8'h0C;
   localparam logic [7:0] ADDR_RESULT = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   localparam logic [15:0] FILTER_RESET = 16'h0007;
   localparam logic [15:0] OFFSET_FACTORY = 16'h0000;
   localparam logic [15:0] GAIN_FACTORY = 16'h5555;

   localparam int FLT_CHOP = 15;
   localparam int FLT_RAVG = 14;
   localparam int FLT_AF_LSB = 8;
   localparam int FLT_MODIFY = 7;
   localparam int FLT_SF_LSB = 0;
   localparam int MODE_PWR_LSB = 3;
   localparam int MODE_FMT = 6;

   localparam logic [2:0] MODE_IDLE = 3'h0;
   localparam logic [2:0] MODE_CONVERT = 3'h1;
   localparam logic [2:0] MODE_SELF_OFFSET = 3'h4;
   localparam logic [2:0] MODE_SELF_GAIN = 3'h5;
   localparam logic [2:0] MODE_SYS_OFFSET = 3'h6;
   localparam logic [2:0] MODE_SYS_GAIN = 3'h7;

   localparam logic [1:0] PWR_NORMAL = 2'h0;
   localparam logic [1:0] PWR_LOW = 2'h1;
   localparam logic [1:0] PWR_LOW_PLUS = 2'h2;

   localparam logic [1:0] SEL_EXTERNAL = 2'h0;
   localparam logic [1:0] SEL_ZERO = 2'h1;
   localparam logic [1:0] SEL_FULL = 2'h2;

   localparam logic [2:0] SETTLE_CHOP = 3'h2;
   localparam logic [2:0] SETTLE_PLAIN = 3'h3;
   localparam logic [6:0] AVG_EXTRA_CHOP = 7'h3;
   localparam logic [6:0] AVG_EXTRA_PLAIN = 7'h1;

   localparam int DEC_UNIT_SHIFT = 6;
   localparam int GAIN_SHIFT = 14;
   localparam logic signed [33:0] ROUND_HALF = 34'sh0_0000_2000;
   localparam logic [31:0] GAIN_TARGET = 32'h2000_0000;

   typedef struct packed {
      logic valid;
      logic signed [23:0] data;
   } sample_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_CAL = 3'b100
   } ctl_state_t;
endpackage
`default_nettype wire

// >>> src/sinc3_decimator.sv
/*
 Third-order sinc decimator for a one-bit modulator stream, with an optional
 second notch at 1.333 times the first. Assumes tick_i marks each modulator bit.
*/
`timescale 1ns/1ns
`default_nettype none
module sinc3_decimator (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic restart_i,
   input wire logic tick_i,
   input wire logic bit_i,
   input wire logic [6:0] sf_i,
   input wire logic modify_i,
   output adc_filter_pkg::sample_t out_o
);
   typedef struct packed {
      logic [12:0] cnt;
      logic signed [40:0] i1, i2, i3, a1, a2, a3, b1, b2, b3, yb;
      adc_filter_pkg::sample_t out;
   } dec_t;

   dec_t s_r, s_nxt;
   logic [13:0] r_len;
   logic [12:0] last_a, last_b;
   logic [5:0] shl;
   logic signed [40:0] x, ya, y, yn;

   function automatic logic [3:0] clog2_8(input logic [7:0] v);
      logic [3:0] k;
      k = 4'h0;
      for (int i = 0; i < 8; i++) begin
         if ((8'h01 << i) < v) k = 4'(i + 1);
      end
      return k;
   endfunction

   always_comb begin
      s_nxt = s_r;
      s_nxt.out.valid = 1'b0;
      r_len = ({7'h00, sf_i} + 14'h0001) << adc_filter_pkg::DEC_UNIT_SHIFT;
      last_a = 13'(r_len - 14'h0001);
      // Second comb chain samples 3/8 of a window early to place the extra notch.
      last_b = 13'(r_len - (r_len >> 2) - (r_len >> 3) - 14'h0001);
      shl = 6'(6'd39 - 6'd3 * (6'd6 + {2'h0, clog2_8({1'b0, sf_i} + 8'h01)}));
      x = bit_i ? 41'sh000_0000_0001 : -41'sh000_0000_0001;
      ya = '0;
      y = '0;
      yn = '0;
      if (restart_i) begin
         s_nxt = '0;
      end else if (tick_i) begin
         s_nxt.i1 = s_r.i1 + x;
         s_nxt.i2 = s_r.i2 + s_nxt.i1;
         s_nxt.i3 = s_r.i3 + s_nxt.i2;
         s_nxt.cnt = s_r.cnt + 13'h0001;
         if (s_r.cnt == last_b) begin
            s_nxt.b1 = s_nxt.i3;
            s_nxt.b2 = s_nxt.i3 - s_r.b1;
            s_nxt.b3 = s_nxt.b2 - s_r.b2;
            s_nxt.yb = s_nxt.b3 - s_r.b3;
         end
         if (s_r.cnt == last_a) begin
            s_nxt.cnt = '0;
            s_nxt.a1 = s_nxt.i3;
            s_nxt.a2 = s_nxt.i3 - s_r.a1;
            s_nxt.a3 = s_nxt.a2 - s_r.a2;
            ya = s_nxt.a3 - s_r.a3;
            y = modify_i ? (ya + s_nxt.yb) >>> 1 : ya;
            yn = y <<< shl;
            s_nxt.out.valid = 1'b1;
            s_nxt.out.data = yn[40:17];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign out_o = s_r.out;
endmodule // sinc3_decimator
`default_nettype wire

// >>> tb/adc_filter_calibration_props.sv
/*
 Port checker for the ADC filter block: bus answers, modulator tick spacing,
 power field and input selection after mode writes.
 Assumes HREADY_I is tied to HREADYOUT_O.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_filter_calibration_chk (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   input wire logic MOD_TICK_O,
   input wire logic [1:0] INPUT_SEL_O,
   input wire logic [1:0] POWER_MODE_O
);
   logic take;
   logic rd_r;
   logic wm_r;
   logic ok_r;
   logic [7:0] gap_r;
   logic [1:0] pwr_r;
   logic [7:0] want;
   assign take = HSEL_I && HTRANS_I[1] && HREADY_I;
   assign want = (POWER_MODE_O == adc_filter_pkg::PWR_NORMAL) ? 8'h26 : 8'h97;
   // A tick gap is only judged once a tick has been seen with the power field steady.
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rd_r <= 1'b0;
         wm_r <= 1'b0;
         ok_r <= 1'b0;
         gap_r <= 8'h00;
         pwr_r <= 2'h0;
      end else begin
         rd_r <= take && !HWRITE_I;
         wm_r <= take && HWRITE_I && HADDR_I[7:0] == adc_filter_pkg::ADDR_MODE;
         gap_r <= MOD_TICK_O ? 8'h00 : gap_r + 8'h01;
         pwr_r <= POWER_MODE_O;
         if (wm_r || POWER_MODE_O != pwr_r) begin
            ok_r <= 1'b0;
         end else if (MOD_TICK_O) begin
            ok_r <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   property p_ready;
      HREADYOUT_O && !HRESP_O;
   endproperty
   a_ready: assert property (p_ready) else $error("bus answer not ready and okay");
   property p_rdata;
      !rd_r |-> HRDATA_O == 32'h0000_0000;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside a read data phase");
   property p_pulse;
      MOD_TICK_O |=> !MOD_TICK_O;
   endproperty
   a_pulse: assert property (p_pulse) else $error("tick longer than one cycle");
   property p_gap;
      MOD_TICK_O && ok_r && pwr_r == POWER_MODE_O |-> gap_r == want;
   endproperty
   a_gap: assert property (p_gap) else $error("tick came early");
   property p_due;
      ok_r && !wm_r && pwr_r == POWER_MODE_O && gap_r == want |-> MOD_TICK_O;
   endproperty
   a_due: assert property (p_due) else $error("tick came late");
   property p_pwr;
      wm_r |=> POWER_MODE_O == $past(HWDATA_I[4:3]);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power field not taken");
   property p_self;
      wm_r && HWDATA_I[2:1] == 2'h2 |=> INPUT_SEL_O ==
         ($past(HWDATA_I[0]) ? adc_filter_pkg::SEL_FULL : adc_filter_pkg::SEL_ZERO);
   endproperty
   a_self: assert property (p_self) else $error("self calibration input wrong");
   property p_ext;
      wm_r && HWDATA_I[2:1] != 2'h2 |=> INPUT_SEL_O == adc_filter_pkg::SEL_EXTERNAL;
   endproperty
   a_ext: assert property (p_ext) else $error("external input not selected");
endmodule // adc_filter_calibration_chk
bind adc_filter_calibration adc_filter_calibration_chk u_adc_filter_calibration_chk (
   .CLK_I, .RST_N_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HWDATA_I, .HREADY_I,
   .HRDATA_O, .HREADYOUT_O, .HRESP_O, .MOD_TICK_O, .INPUT_SEL_O, .POWER_MODE_O
);
`default_nettype wire

// >>> tb/modulator_model.sv
/*
 First-order one-bit modulator standing in for the analog front end.
 Assumes one new bit per tick and that the chop phase swaps the input polarity.
*/
`timescale 1ns/1ns
`default_nettype none
module modulator_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic chop_i,
   input wire logic [1:0] sel_i,
   input wire logic signed [7:0] ext_i,
   output logic bit_o
);
   logic signed [9:0] lvl;
   logic signed [9:0] nxt;
   logic signed [9:0] acc_r;
   always_comb begin
      lvl = {{2{ext_i[7]}}, ext_i};
      if (sel_i == adc_filter_pkg::SEL_ZERO) begin
         lvl = 10'sh000;
      end else if (sel_i == adc_filter_pkg::SEL_FULL) begin
         lvl = 10'sh07F;
      end
      if (chop_i) begin
         lvl = -lvl;
      end
      nxt = acc_r + lvl - (bit_o ? 10'sh07F : 10'sh381);
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         acc_r <= 10'sh000;
         bit_o <= 1'b0;
      end else if (tick_i) begin
         acc_r <= nxt;
         bit_o <= !nxt[9];
      end
   end
endmodule // modulator_model
`default_nettype wire

// >>> tb/test_adc_filter_calibration.sv
/*
 Self-checking bench for the ADC filter block: registers over AHB-Lite, tick
 rates, conversion and calibration timing, and result saturation.
 Assumes the modulator model on the far side and a 20 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module test_adc_filter_calibration;
   localparam logic [7:0] flt_a = adc_filter_pkg::ADDR_FILTER;
   localparam logic [7:0] mode_a = adc_filter_pkg::ADDR_MODE;
   localparam logic [7:0] ofs_a = adc_filter_pkg::ADDR_OFFSET;
   localparam logic [7:0] gn_a = adc_filter_pkg::ADDR_GAIN;
   localparam logic [7:0] res_a = adc_filter_pkg::ADDR_RESULT;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic signed [7:0] ext = 8'sh00;
   logic [31:0] hrdata;
   logic hready;
   logic mbit;
   logic tick;
   logic chop;
   logic [1:0] sel;
   logic [1:0] pwr;
   int error_cnt = 0;
   int compares = 0;
   int ticks = 0;
   always #25 clk = ~clk;
   always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;
   adc_filter_calibration u_adc_filter_calibration (
      .CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .MOD_BIT_I(mbit),
      .MOD_TICK_O(tick), .CHOP_PHASE_O(chop), .INPUT_SEL_O(sel), .POWER_MODE_O(pwr)
   );
   modulator_model u_modulator_model (
      .clk_i(clk), .rst_n_i(rst_n), .tick_i(tick), .chop_i(chop), .sel_i(sel),
      .ext_i(ext), .bit_o(mbit)
   );
   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      compares++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      int n;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      n = 0;
      do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      n = 0;
      do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
      rd = hrdata;
      hsel <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(what, e, x);
   endtask
   task automatic tick_gap(output int g);
      g = 0;
      do begin @(posedge clk); g++; end while (tick !== 1'b1 && g < 400);
      g = 0;
      do begin @(posedge clk); g++; end while (tick !== 1'b1 && g < 400);
   endtask
   // Conversions end on the ready flag, calibrations on busy falling.
   task automatic wait_stat(input int b, input int t0, output int dt);
      logic [31:0] x;
      int n;
      n = 0;
      do begin bus(1'b0, adc_filter_pkg::ADDR_STATUS, 32'h0, x); n++; end
      while (x[b] !== (b == 0) && n < 20000);
      dt = ticks - t0;
   endtask
   task automatic go(input logic [31:0] f, input logic [31:0] m, output int t0);
      logic [31:0] x;
      wr(mode_a, 32'h0);
      bus(1'b0, res_a, 32'h0, x);
      wr(flt_a, f);
      wr(mode_a, m);
      t0 = ticks;
   endtask
   task automatic timed(input logic [31:0] f, input logic [31:0] m, input logic [1:0] s,
                        input int b, input int lo, input int hi);
      int t;
      int d;
      go(f, m, t);
      chk("input select", {30'h0, s}, {30'h0, sel});
      wait_stat(b, t, d);
      chk_rng("ticks to finish", lo, hi, d);
   endtask
   task automatic t_reset();
      rd_chk("filter", flt_a, 32'h0000_0007);
      rd_chk("offset", ofs_a, 32'(adc_filter_pkg::OFFSET_FACTORY));
      rd_chk("gain", gn_a, 32'(adc_filter_pkg::GAIN_FACTORY));
      rd_chk("mode", mode_a, 32'h0);
      rd_chk("unmapped", 8'h1C, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_rates();
      int g;
      wr(flt_a, 32'h0000_961F);
      rd_chk("filter", flt_a, 32'h0000_961F);
      wr(flt_a, 32'h0000_BF1D);
      rd_chk("filter", flt_a, 32'h0000_BF1D);
      wr(mode_a, 32'h08);
      chk("power", 32'h1, {30'h0, pwr});
      tick_gap(g);
      chk_rng("low tick gap", 152, 152, g);
      wr(mode_a, 32'h10);
      chk("power", 32'h2, {30'h0, pwr});
      tick_gap(g);
      chk_rng("low plus tick gap", 152, 152, g);
      wr(mode_a, 32'h0);
      tick_gap(g);
      chk_rng("normal tick gap", 39, 39, g);
      $display("test rates done");
   endtask
   task automatic t_conv();
      wr(gn_a, 32'h0000_FFFF);
      rd_chk("gain", gn_a, 32'h0000_FFFF);
      ext <= 8'sh7F;
      timed(32'h0, 32'h1, 2'h0, 0, 191, 194);
      rd_chk("result", res_a, 32'h0000_7FFF);
      timed(32'h4000, 32'h41, 2'h0, 0, 255, 258);
      rd_chk("result", res_a, 32'h0000_FFFF);
      wr(mode_a, 32'h0);
      wr(ofs_a, 32'h0000_7FFF);
      wr(gn_a, 32'h0000_5555);
      ext <= 8'sh00;
      timed(32'h8000, 32'h1, 2'h0, 0, 383, 386);
      rd_chk("result", res_a, 32'h0000_8000);
      wr(mode_a, 32'h0);
      chk("chop phase", 32'h0, {31'h0, chop});
      $display("test conversion done");
   endtask
   task automatic t_cal();
      logic [31:0] x;
      wr(gn_a, 32'h0000_5555);
      timed(32'h0, 32'h4, adc_filter_pkg::SEL_ZERO, 2, 191, 194);
      rd_chk("mode", mode_a, 32'h0);
      rd_chk("gain", gn_a, 32'h0000_5555);
      chk("input select", 32'h0, {30'h0, sel});
      bus(1'b0, ofs_a, 32'h0, x);
      timed(32'h0, 32'h5, adc_filter_pkg::SEL_FULL, 2, 383, 386);
      rd_chk("offset", ofs_a, x);
      $display("test calibration done");
   endtask
   task automatic t_abort();
      logic [31:0] x;
      int t;
      int d;
      bus(1'b0, ofs_a, 32'h0, x);
      go(32'h0, 32'h1, t);
      repeat (2000) @(posedge clk);
      wr(ofs_a, 32'h0000_0456);
      rd_chk("offset", ofs_a, x);
      wr(mode_a, 32'h6);
      t = ticks;
      wait_stat(2, t, d);
      chk_rng("abort ticks", 191, 194, d);
      rd_chk("mode", mode_a, 32'h0);
      $display("test abort done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_rates();
      t_conv();
      t_cal();
      t_abort();
      report_and_stop();
   end
   initial begin
      #(95_000 * 50);
      error_cnt++;
      $display("[ERR] watchdog expected finish seen hang");
      report_and_stop();
   end
endmodule // test_adc_filter_calibration
`default_nettype wire
